// >>> logic/ism_cmp_edge.sv
// Comparator output synchroniser and configurable sticky edge flag
`timescale 1ns/100ps
`include "ism_defs.svh"

module ism_cmp_edge
  import ism_pkg::*;
(
  input  wire logic       pclk,                 // System clock
  input  wire logic       presetn,              // Async reset, active low
  input  wire logic       comparator_out,       // Raw comparator output
  input  wire logic [1:0] edge_sel,             // Edge selection
  input  wire logic       flag_clear,           // Clear pulse for the flag
  output logic            comparator_edge_flag  // Sticky edge flag
);

  ism_edge_s st;
  ism_edge_s next_st;
  logic      rise;
  logic      fall;
  logic      hit;

  // ==========================================================================
  // Next state
  always_comb begin
    next_st       = st;
    next_st.sync1 = comparator_out;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    rise          = st.sync2 & ~st.prev;
    fall          = ~st.sync2 & st.prev;
    case (edge_sel)
      `ISM_EDGE_RISE: hit = rise;
      `ISM_EDGE_FALL: hit = fall;
      default:        hit = rise | fall;
    endcase
    // A new edge wins over a clear in the same cycle
    next_st.flag = (st.flag & ~flag_clear) | hit;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign comparator_edge_flag = st.flag;

endmodule : ism_cmp_edge

// >>> logic/ism_defs.svh
// Constants for the peripheral interrupt source map, NMI select and vector base
// ==========================================================================
// What this block does
// - Second I2C request drives line 7, first I2C request drives line 8.
// - Line 10 is high while any of the four timer channel flags is set.
// - Line 11 is high for comparator request or touch sense request.
// - Comparator edge flag sets on rising, falling or both edges as configured.
// - Watchdog on 12, brown-out on 13, wake timer on 15, counter/timer on 23.
// - Converter drives sequence A 16, sequence B 17, threshold 18, overrun 19.
// - Lines 24 to 31 follow pin event status bits 0 to 7 in order.
// - NMI is raised from a selected peripheral line or by software.
// - NMI outranks every other interrupt; only reset is higher.
// - A source-select register picks which mapped line drives the NMI.
// - Vector table holds initial stack pointer then handler entry addresses.
// - Vector table base is zero after reset until software writes it.
// - Writable vector base offset register relocates all vector fetches.
// - Among equal priorities the lowest line number is serviced first.
// - 32 lines, four priority levels each, masking by priority level.
`ifndef ISM_DEFS_SVH
`define ISM_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define ISM_OFS_NMI_SRC    12'h000
`define ISM_OFS_SW_NMI     12'h004
`define ISM_OFS_VEC_BASE   12'h008
`define ISM_OFS_LINE_EN    12'h00C
`define ISM_OFS_PRIO_LO    12'h010
`define ISM_OFS_PRIO_HI    12'h014
`define ISM_OFS_PRIO_MASK  12'h018
`define ISM_OFS_RAW_LINES  12'h01C
`define ISM_OFS_ACTIVE     12'h020
`define ISM_OFS_CMP_CFG    12'h024
`define ISM_OFS_INT_STATUS 12'h028
`define ISM_OFS_INT_MASK   12'h02C

// ==========================================================================
// Field positions
`define ISM_NMI_EN_BIT     31
`define ISM_ACTIVE_VLD_BIT 5
`define ISM_CMP_FLAG_BIT   2
`define ISM_VEC_BASE_LSB   7
`define ISM_EV_NMI         0
`define ISM_EV_CMP         1
`define ISM_EV_IRQ         2

// ==========================================================================
// Line numbers
`define ISM_LN_I2C1        7
`define ISM_LN_I2C0        8
`define ISM_LN_MRT         10
`define ISM_LN_CMP         11
`define ISM_LN_WDT         12
`define ISM_LN_BOD         13
`define ISM_LN_WKT         15
`define ISM_LN_SEQA        16
`define ISM_LN_SEQB        17
`define ISM_LN_THCMP       18
`define ISM_LN_OVR         19
`define ISM_LN_CTR         23
`define ISM_LN_PIN0        24

// ==========================================================================
// Reset values and vector layout
`define ISM_VEC_BASE_RST   25'h0000000
`define ISM_SP_OFS         32'h00000000
`define ISM_NMI_VEC_OFS    32'h00000008
`define ISM_IRQ_VEC_OFS    32'h00000040
`define ISM_EDGE_RISE      2'h0
`define ISM_EDGE_FALL      2'h1

`endif

// >>> logic/ism_irq_map.sv
// Peripheral interrupt source map with NMI select, line arbiter and vector base
`timescale 1ns/100ps
`include "ism_defs.svh"

module ism_irq_map
  import ism_pkg::*;
(
  input  wire logic        pclk,                   // System clock, 20 MHz
  input  wire logic        presetn,                // Async reset, active low
  // APB slave
  input  wire logic        psel,                   // Slave select
  input  wire logic        penable,                // Access phase
  input  wire logic        pwrite,                 // Write when high
  input  wire logic [11:0] paddr,                  // Byte address
  input  wire logic [31:0] pwdata,                 // Write data
  output logic [31:0]      prdata,                 // Read data
  output logic             pready,                 // Always ready
  output logic             pslverr,                // Unmapped address
  // Peripheral requests
  input  wire logic        second_i2c_request,     // Second I2C controller
  input  wire logic        first_i2c_request,      // First I2C controller
  input  wire logic [3:0]  timer_channel_flag,     // Multi-rate timer flags
  input  wire logic        comparator_out,         // Comparator output, async
  input  wire logic        touch_sense_request,    // Capacitive touch
  input  wire logic        watchdog_warning_flag,  // Watchdog warning
  input  wire logic        brownout_request,       // Brown-out level
  input  wire logic        wake_alarm_flag,        // Self-wake timer alarm
  input  wire logic        conv_seq_a_done,        // Converter sequence A
  input  wire logic        conv_seq_b_done,        // Converter sequence B
  input  wire logic        conv_threshold_hit,     // Converter threshold
  input  wire logic        conv_overrun,           // Converter overrun
  input  wire logic        counter_timer_request,  // Counter/timer
  input  wire logic [7:0]  pin_event_status,       // Pin interrupt status
  // Core side
  output logic [31:0]      mapped_lines,           // Vectored line levels
  output logic             nmi_request,            // Non-maskable request
  output logic             irq_request,            // Vectored request
  output logic [4:0]       irq_number,             // Winning line
  output logic [31:0]      vector_addr,            // Handler vector address
  output logic [31:0]      stack_ptr_addr,         // Initial stack pointer slot
  output logic             irq_out                 // Block status interrupt
);

  ism_state_s  st;
  ism_state_s  next_st;
  logic        cmp_flag;
  logic        cmp_clear;
  logic [31:0] lines;
  logic        setup;
  logic        wr;
  logic        nmi_lvl;
  logic        win_vld;
  logic [4:0]  win_num;
  logic [1:0]  win_prio;
  logic [31:0] rd;
  logic        hit;
  logic [2:0]  events;

  // ==========================================================================
  // Priority field of one line
  function automatic logic [1:0] prio_of(input logic [63:0] p, input logic [4:0] n);
    prio_of = p[{n, 1'b0} +: 2];
  endfunction : prio_of

  // ==========================================================================
  // Comparator edge flag
  ism_cmp_edge u_cmp_edge (
    .pclk                 (pclk),
    .presetn              (presetn),
    .comparator_out       (comparator_out),
    .edge_sel             (st.edge_sel),
    .flag_clear           (cmp_clear),
    .comparator_edge_flag (cmp_flag)
  );

  // ==========================================================================
  // Line map; levels pass straight through except the comparator's sticky edge flag ORed with touch sense on line 11 and the timer flags ORed onto line 10
  always_comb begin
    lines                     = '0;
    lines[`ISM_LN_I2C1]       = second_i2c_request;
    lines[`ISM_LN_I2C0]       = first_i2c_request;
    lines[`ISM_LN_MRT]        = |timer_channel_flag;
    lines[`ISM_LN_CMP]        = cmp_flag | touch_sense_request;
    lines[`ISM_LN_WDT]        = watchdog_warning_flag;
    lines[`ISM_LN_BOD]        = brownout_request;
    lines[`ISM_LN_WKT]        = wake_alarm_flag;
    lines[`ISM_LN_SEQA]       = conv_seq_a_done;
    lines[`ISM_LN_SEQB]       = conv_seq_b_done;
    lines[`ISM_LN_THCMP]      = conv_threshold_hit;
    lines[`ISM_LN_OVR]        = conv_overrun;
    lines[`ISM_LN_CTR]        = counter_timer_request;
    lines[`ISM_LN_PIN0 +: 8]  = pin_event_status;
  end

  // ==========================================================================
  // Arbiter: lowest level value wins, then lowest line number
  always_comb begin
    win_vld  = 1'b0;
    win_num  = '0;
    win_prio = '0;
    for (int i = 0; i < 32; i++) begin
      if (lines[i] && st.line_en[i] &&
          (st.prio_mask == 2'h0 || prio_of(st.prio, 5'(i)) < st.prio_mask)) begin
        if (!win_vld || prio_of(st.prio, 5'(i)) < win_prio) begin
          win_vld  = 1'b1;
          win_num  = 5'(i);
          win_prio = prio_of(st.prio, 5'(i));
        end
      end
    end
  end

  // ==========================================================================
  // Read decode
  always_comb begin
    hit = 1'b1;
    rd  = '0;
    case (paddr)
      `ISM_OFS_NMI_SRC: begin
        rd[`ISM_NMI_EN_BIT] = st.nmi_en;
        rd[4:0]             = st.nmi_sel;
      end
      `ISM_OFS_SW_NMI:     rd[0] = st.sw_nmi;
      `ISM_OFS_VEC_BASE:   rd[31:`ISM_VEC_BASE_LSB] = st.vec_base;
      `ISM_OFS_LINE_EN:    rd = st.line_en;
      `ISM_OFS_PRIO_LO:    rd = st.prio[31:0];
      `ISM_OFS_PRIO_HI:    rd = st.prio[63:32];
      `ISM_OFS_PRIO_MASK:  rd[1:0] = st.prio_mask;
      `ISM_OFS_RAW_LINES:  rd = lines;
      `ISM_OFS_ACTIVE: begin
        rd[`ISM_ACTIVE_VLD_BIT] = st.irq_req;
        rd[4:0]                 = st.irq_num;
      end
      `ISM_OFS_CMP_CFG: begin
        rd[1:0]                = st.edge_sel;
        rd[`ISM_CMP_FLAG_BIT]  = cmp_flag;
      end
      `ISM_OFS_INT_STATUS: rd[2:0] = st.int_status;
      `ISM_OFS_INT_MASK:   rd[2:0] = st.int_mask;
      default:             hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st   = st;
    setup     = psel & ~penable;
    wr        = psel & penable & pwrite;
    cmp_clear = wr && paddr == `ISM_OFS_CMP_CFG && pwdata[`ISM_CMP_FLAG_BIT];

    // Read data and error are prepared in the setup phase for zero wait states
    if (setup) begin
      next_st.prdata  = (hit && !pwrite) ? rd : '0;
      next_st.pslverr = ~hit;
    end

    // Register writes
    if (wr) begin
      case (paddr)
        `ISM_OFS_NMI_SRC: begin
          next_st.nmi_en  = pwdata[`ISM_NMI_EN_BIT];
          next_st.nmi_sel = pwdata[4:0];
        end
        `ISM_OFS_SW_NMI:     next_st.sw_nmi = pwdata[0];
        `ISM_OFS_VEC_BASE:   next_st.vec_base = pwdata[31:`ISM_VEC_BASE_LSB];
        `ISM_OFS_LINE_EN:    next_st.line_en = pwdata;
        `ISM_OFS_PRIO_LO:    next_st.prio[31:0] = pwdata;
        `ISM_OFS_PRIO_HI:    next_st.prio[63:32] = pwdata;
        `ISM_OFS_PRIO_MASK:  next_st.prio_mask = pwdata[1:0];
        `ISM_OFS_CMP_CFG:    next_st.edge_sel = pwdata[1:0];
        `ISM_OFS_INT_MASK:   next_st.int_mask = pwdata[2:0];
        default: ;
      endcase
    end

    // NMI from the selected line or software
    nmi_lvl         = (st.nmi_en & lines[st.nmi_sel]) | st.sw_nmi;
    next_st.nmi_req = nmi_lvl;

    // A pending NMI holds back every vectored request
    next_st.irq_req = win_vld & ~nmi_lvl;
    next_st.irq_num = win_num;
    if (nmi_lvl) begin
      next_st.vec_addr = {st.vec_base, 7'h00} + `ISM_NMI_VEC_OFS;
    end else begin
      next_st.vec_addr = {st.vec_base, 7'h00} + `ISM_IRQ_VEC_OFS
                         + {25'h0000000, win_num, 2'h0};
    end

    // Sticky events, a new event wins over a write-one clear
    next_st.cmp_prev = cmp_flag;
    events = '0;
    events[`ISM_EV_NMI] = nmi_lvl & ~st.nmi_req;
    events[`ISM_EV_CMP] = cmp_flag & ~st.cmp_prev;
    events[`ISM_EV_IRQ] = next_st.irq_req & ~st.irq_req;
    if (wr && paddr == `ISM_OFS_INT_STATUS) begin
      next_st.int_status = st.int_status & ~pwdata[2:0];
    end
    next_st.int_status = next_st.int_status | events;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.vec_base <= `ISM_VEC_BASE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata         = st.prdata;
  assign pready         = 1'b1;
  assign pslverr        = st.pslverr;
  assign mapped_lines   = lines;
  assign nmi_request    = st.nmi_req;
  assign irq_request    = st.irq_req;
  assign irq_number     = st.irq_num;
  assign vector_addr    = st.vec_addr;
  assign stack_ptr_addr = {st.vec_base, 7'h00} + `ISM_SP_OFS;
  assign irq_out        = |(st.int_status & st.int_mask);

endmodule : ism_irq_map

// >>> logic/ism_pkg.sv
// Types for the peripheral interrupt source map
package ism_pkg;

  // ==========================================================================
  // Comparator edge detector state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic flag;
  } ism_edge_s;

  // ==========================================================================
  // Main block state
  typedef struct packed {
    logic        nmi_en;
    logic [4:0]  nmi_sel;
    logic        sw_nmi;
    logic [24:0] vec_base;
    logic [31:0] line_en;
    logic [63:0] prio;
    logic [1:0]  prio_mask;
    logic [1:0]  edge_sel;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;
    logic        cmp_prev;
    logic        nmi_req;
    logic        irq_req;
    logic [4:0]  irq_num;
    logic [31:0] vec_addr;
    logic [31:0] prdata;
    logic        pslverr;
  } ism_state_s;

endpackage : ism_pkg

// >>> sim/ism_irq_map_properties.sv
// Port checker for the interrupt source map
`timescale 1ns/100ps
module ism_irq_map_properties (
  input wire logic        pclk,               // Clock
  input wire logic        presetn,            // Reset
  input wire logic [3:0]  timer_channel_flag, // Timer flags
  input wire logic        touch_sense_request, // Touch
  input wire logic [7:0]  pin_event_status,   // Pin status
  input wire logic [31:0] mapped_lines,       // Lines
  input wire logic        nmi_request,        // NMI
  input wire logic        irq_request,        // IRQ
  input wire logic [4:0]  irq_number,         // Winner
  input wire logic [31:0] vector_addr,        // Vector
  input wire logic [31:0] stack_ptr_addr      // Base
);
  logic [31:0] prev_lines;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_lines <= '0;
    end else begin
      prev_lines <= mapped_lines;
    end
  end
  sequence s_nmi_up;
    !nmi_request ##1 nmi_request;
  endsequence
  a_reserved_tied: assert property ((mapped_lines & 32'h0070427F) == 32'h0)
    else $error("reserved line active");
  a_timer_any: assert property (mapped_lines[10] == |timer_channel_flag)
    else $error("line 10 wrong");
  a_touch_shared: assert property (touch_sense_request |-> mapped_lines[11])
    else $error("line 11 missing touch");
  a_pin_order: assert property (mapped_lines[31:24] == pin_event_status)
    else $error("pin lines wrong");
  a_nmi_first: assert property (s_nmi_up |-> !irq_request)
    else $error("irq beside nmi");
  a_irq_no_nmi: assert property (irq_request |-> !nmi_request)
    else $error("irq while nmi");
  a_irq_vector: assert property (irq_request && $stable(stack_ptr_addr) |->
    vector_addr == stack_ptr_addr + 32'h40 + {25'h0, irq_number, 2'b00})
    else $error("irq vector wrong");
  a_nmi_vector: assert property (nmi_request && $stable(stack_ptr_addr) |->
    vector_addr == stack_ptr_addr + 32'h8) else $error("nmi vector wrong");
  a_irq_line_up: assert property (irq_request |-> prev_lines[irq_number])
    else $error("irq without line");
  a_base_reset: assert property ($rose(presetn) |-> stack_ptr_addr == 32'h0)
    else $error("base not zero");
endmodule : ism_irq_map_properties
bind ism_irq_map ism_irq_map_properties i_ism_irq_map_properties (.*);

// >>> sim/ism_periph_model.sv
// Behavioural peripheral request sources, each held until cleared
`timescale 1ns/100ps
module ism_periph_model (
  input  wire logic [23:0] set_bits, // Flags to raise
  input  wire logic [23:0] clr_bits, // Flags to clear
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Reset
  output logic      [23:0] flags     // Request levels
);
  initial flags = '0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags | set_bits) & ~clr_bits;
    end
  end
endmodule : ism_periph_model

// >>> sim/test_irq_source_map_nmi_vector.sv
// Self-checking bench for the interrupt source map
`timescale 1ns/100ps
`include "ism_defs.svh"
module test_irq_source_map_nmi_vector;
  import ism_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, mapped_lines, vector_addr, stack_ptr_addr;
  logic nmi_request, irq_request, irq_out, second_i2c_request, first_i2c_request;
  logic comparator_out, touch_sense_request, watchdog_warning_flag, brownout_request;
  logic wake_alarm_flag, conv_seq_a_done, conv_seq_b_done, conv_threshold_hit;
  logic conv_overrun, counter_timer_request;
  logic [3:0] timer_channel_flag;
  logic [7:0] pin_event_status;
  logic [4:0] irq_number;
  logic [23:0] set_bits = '0, clr_bits = '0, flags;
  int n_fail = 0, n_compared = 0;
  always #25 pclk = ~pclk;
  assign {pin_event_status, counter_timer_request, conv_overrun, conv_threshold_hit,
          conv_seq_b_done, conv_seq_a_done, wake_alarm_flag, brownout_request,
          watchdog_warning_flag, touch_sense_request, comparator_out,
          timer_channel_flag, first_i2c_request, second_i2c_request} = flags;
  ism_periph_model i_ism_periph_model (.*);
  ism_irq_map i_ism_irq_map (.*);
  // ==========================================================================
  // Bus and check tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : apb
  task automatic poke(input logic [23:0] s, input logic [23:0] c);
    @(posedge pclk);
    set_bits <= s;
    clr_bits <= c;
    @(posedge pclk);
    set_bits <= '0;
    clr_bits <= '0;
    // Comparator flag needs two sync edges and one detect edge after the level change
    repeat (4) @(negedge pclk);
  endtask : poke
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  function automatic logic [31:0] exp_lines(input logic [23:0] f);
    exp_lines = {f[23:16], f[15], 3'h0, f[14:11], f[10], 1'b0, f[9], f[8], f[7],
                 |f[5:2], 1'b0, f[1], f[0], 7'h00};
  endfunction : exp_lines
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    conclude();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(`ISM_OFS_VEC_BASE, 1'b0, '0);
    chk("vec_base", 32'h0, rd);
    chk("stack_slot", 32'h0, stack_ptr_addr);
    apb(12'h100, 1'b0, '0);
    chk("unmapped", 32'h1, {31'h0, err});
    for (int i = 0; i < 24; i++) if (i != 6) begin
      poke(24'h1 << i, '0);
      chk("lines", exp_lines(24'h1 << i), mapped_lines);
      poke('0, 24'h1 << i);
      chk("lines_clr", 32'h0, mapped_lines);
    end
    for (int m = 0; m < 4; m++) begin
      apb(`ISM_OFS_CMP_CFG, 1'b1, {29'h0, 1'b1, m[1:0]});
      poke(24'h40, '0);
      chk("cmp_rise", {31'h0, m != 1}, {31'h0, mapped_lines[11]});
      apb(`ISM_OFS_CMP_CFG, 1'b1, {29'h0, 1'b1, m[1:0]});
      poke('0, 24'h40);
      chk("cmp_fall", {31'h0, m != 0}, {31'h0, mapped_lines[11]});
    end
    apb(`ISM_OFS_CMP_CFG, 1'b1, 32'h4);
    apb(`ISM_OFS_LINE_EN, 1'b1, 32'h00010100);
    poke(24'h802, '0);
    chk("tie_num", 32'd8, {27'h0, irq_number});
    chk("tie_vec", 32'h60, vector_addr);
    apb(`ISM_OFS_ACTIVE, 1'b0, '0);
    chk("active", 32'h28, rd);
    apb(`ISM_OFS_PRIO_LO, 1'b1, 32'h00010000);
    chk("prio_num", 32'd16, {27'h0, irq_number});
    apb(`ISM_OFS_PRIO_HI, 1'b1, 32'h1);
    apb(`ISM_OFS_PRIO_MASK, 1'b1, 32'h1);
    chk("prio_mask", 32'h0, {31'h0, irq_request});
    apb(`ISM_OFS_INT_STATUS, 1'b0, '0);
    chk("status", 32'h6, rd);
    chk("irq_out_off", 32'h0, {31'h0, irq_out});
    apb(`ISM_OFS_INT_MASK, 1'b1, 32'h4);
    chk("irq_out_on", 32'h1, {31'h0, irq_out});
    apb(`ISM_OFS_INT_STATUS, 1'b1, 32'h4);
    chk("irq_out_clr", 32'h0, {31'h0, irq_out});
    apb(`ISM_OFS_PRIO_MASK, 1'b1, 32'h0);
    apb(`ISM_OFS_VEC_BASE, 1'b1, 32'h200000FF);
    apb(`ISM_OFS_VEC_BASE, 1'b0, '0);
    chk("base_rd", 32'h20000080, rd);
    chk("base_slot", 32'h20000080, stack_ptr_addr);
    chk("base_vec", 32'h200000E0, vector_addr);
    // Line 12 stays disabled while it serves as the NMI source
    apb(`ISM_OFS_NMI_SRC, 1'b1, 32'h8000000C);
    poke(24'h100, '0);
    chk("nmi_src", 32'h1, {31'h0, nmi_request});
    chk("nmi_first", 32'h0, {31'h0, irq_request});
    chk("nmi_vec", 32'h20000088, vector_addr);
    apb(`ISM_OFS_RAW_LINES, 1'b0, '0);
    chk("raw_lines", 32'h00011100, rd);
    poke('0, 24'h100);
    chk("nmi_drop", 32'h0, {31'h0, nmi_request});
    apb(`ISM_OFS_SW_NMI, 1'b1, 32'h1);
    chk("nmi_sw", 32'h1, {31'h0, nmi_request});
    apb(`ISM_OFS_SW_NMI, 1'b1, 32'h0);
    apb(`ISM_OFS_INT_STATUS, 1'b0, '0);
    chk("status_nmi", 32'h1, {31'h0, rd[0]});
    conclude();
  end
endmodule : test_irq_source_map_nmi_vector
